// File: hdl/startup_pkg.sv
// ==========================================================
// shared constants for reference clock start-up control
// ==========================================================
package startup_pkg;
    // system clock timing
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned MS_NS = 1000000;
    // cycles per millisecond, at least one
    localparam int unsigned MS_CYCLES =
        (MS_NS / CLK_PERIOD_NS) < 1 ? 1 : (MS_NS / CLK_PERIOD_NS);
    // millisecond figures of the start-up sequence
    localparam logic [5:0] BASE_DELAY_MS = 6'h05;
    localparam logic [5:0] ACC250_MS = 6'h02;
    localparam logic [5:0] RADIO_MS = 6'h06;
    // reference frequency setting, in kHz
    localparam logic [15:0] FREQ_MIN_KHZ = 16'h2EE0;
    localparam logic [15:0] FREQ_MAX_KHZ = 16'hCB20;
    localparam logic [15:0] FREQ_STEP_KHZ = 16'h00FA;
    localparam logic [15:0] FREQ_DEFAULT_KHZ = 16'h6590;
    localparam int unsigned PHONE_FREQ_N = 9;
    localparam logic [15:0] PHONE_FREQ_KHZ [PHONE_FREQ_N] = '{
        16'h3840, 16'h3C00, 16'h3F48, 16'h41A0, 16'h4B00,
        16'h4BF0, 16'h4CE0, 16'h4D58, 16'h9600};
    // sequencer states, gray along idle -> wait -> run
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_RUN = 2'h3
    } seq_state_t;
endpackage : startup_pkg

// File: hdl/ms_tick_if.sv
`timescale 1ns/100ps
// ==========================================================
// millisecond tick carrier between sequencer and timer
// ==========================================================
interface ms_tick_if;
    logic en; // clock enable, freezes the timer
    logic clear; // restart the millisecond phase
    logic tick; // one-cycle pulse each millisecond
    modport timer (input en, input clear, output tick);
    modport user (output en, output clear, input tick);
endinterface : ms_tick_if

// File: hdl/ms_timer.sv
`timescale 1ns/100ps
// ==========================================================
// millisecond tick generator, also the 1 kHz watchdog rate
// ==========================================================
module ms_timer
    import startup_pkg::*;
#(
    parameter int unsigned MS_CYC = MS_CYCLES
)
(
    input wire logic clk,
    input wire logic rst_b,
    ms_tick_if.timer bus
);
    logic [14:0] cnt_r; // cycles into the current millisecond
    logic [14:0] cnt_nxt;
    logic at_end; // last cycle of the millisecond

    // =======================================================
    // next count
    // =======================================================
    always_comb
    begin
        at_end = (cnt_r == 15'(MS_CYC - 1));
        cnt_nxt = cnt_r;
        if (bus.clear)
            cnt_nxt = '0; // restart so phases align to the sequence
        else if (at_end)
            cnt_nxt = '0;
        else
            cnt_nxt = cnt_r + 15'h0001;
    end

    // tick on every enabled last cycle; gating it by clear would loop
    // back through the sequencer's next state into clear itself
    assign bus.tick = bus.en && at_end;

    // =======================================================
    // count register
    // =======================================================
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_r <= '0;
        else if (bus.en)
            cnt_r <= cnt_nxt;
    end

    // tick position check: a tick only on the last cycle of the millisecond
    tick_once_a: assert property (@(posedge clk) disable iff (!rst_b)
        bus.tick |-> cnt_r == 15'(MS_CYC - 1))
        else $error("millisecond tick at wrong count");
endmodule : ms_timer

// File: hdl/ref_clock_startup_control.sv
`timescale 1ns/100ps
// What this block does
// RULE1: accept 12 to 52 MHz reference setting
// RULE2: pll locks to reference or 1 kHz watchdog
// RULE3: low power picks watchdog by link activity
// RULE4: setting in kHz, any 250 kHz multiple
// RULE5: also accept the listed phone oscillator frequencies
// RULE6: unusable setting falls back to 26000 kHz
// RULE7: grounded drive output selects external reference input
// RULE8: wait 5 ms after clock request before firmware
// RULE9: extension adds 1 to 31 ms; zero default
// RULE10: reference within 250 ppm 2 ms after start
// RULE11: radio allowed 6 ms after firmware start
// RULE12: firmware held until whole delay has expired
module ref_clock_startup_control
    import startup_pkg::*;
#(
    parameter int unsigned MS_CYC = MS_CYCLES
)
(
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic CLK_EN,
    input wire logic WAKE_REQ,
    input wire logic [15:0] REFERENCE_FREQ_SETTING,
    input wire logic [4:0] CLOCK_STARTUP_EXTENSION,
    input wire logic CRYSTAL_DRIVE_GROUNDED,
    input wire logic LOW_POWER,
    input wire logic LINK_ACTIVE,
    output logic SYS_CLK_REQ,
    output logic FW_RUN,
    output logic [15:0] FREQ_KHZ,
    output logic FREQ_VALID,
    output logic EXT_REF_MODE,
    output logic PLL_SRC_WDOG,
    output logic ACC250_DUE,
    output logic RADIO_ALLOWED,
    output logic WDOG_TICK
);
    // =======================================================
    // millisecond timer
    // =======================================================
    ms_tick_if tick_bus ();
    seq_state_t state_r; // sequencer state
    seq_state_t state_nxt;
    logic [5:0] ms_cnt_r; // elapsed milliseconds in this phase
    logic [5:0] ms_cnt_nxt;
    logic [5:0] delay_r; // captured start-up delay in ms
    logic [5:0] delay_nxt;
    logic wait_done; // last millisecond of the delay ends

    ms_timer #(.MS_CYC(MS_CYC)) u_timer (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .bus(tick_bus)
    );

    assign tick_bus.en = CLK_EN;
    // restart the phase on entry to wait and to run
    assign tick_bus.clear = (state_r != state_nxt) && CLK_EN;
    // the 1 kHz watchdog rate shares the millisecond tick
    assign WDOG_TICK = tick_bus.tick; // [RULE2]

    // =======================================================
    // reference frequency check
    // =======================================================
    logic [PHONE_FREQ_N-1:0] phone_hit; // per-entry match
    logic in_range; // inside 12 to 52 MHz
    logic on_step; // whole multiple of 250 kHz
    logic freq_ok; // setting usable
    logic [15:0] freq_nxt;

    for (genvar i = 0; i < PHONE_FREQ_N; i++)
    begin : g_phone
        assign phone_hit[i] =
            (REFERENCE_FREQ_SETTING == PHONE_FREQ_KHZ[i]); // [RULE5]
    end

    // next frequency: the setting if usable, else the default
    always_comb
    begin
        in_range = (REFERENCE_FREQ_SETTING >= FREQ_MIN_KHZ) &&
            (REFERENCE_FREQ_SETTING <= FREQ_MAX_KHZ); // [RULE1]
        on_step = ((REFERENCE_FREQ_SETTING % FREQ_STEP_KHZ)
            == 16'h0000); // [RULE4]
        freq_ok = in_range && (on_step || (|phone_hit));
        // out-of-range or odd values never reach the pll setup
        freq_nxt = freq_ok ? REFERENCE_FREQ_SETTING
            : FREQ_DEFAULT_KHZ; // [RULE6]
    end

    // =======================================================
    // frequency and reference mode registers
    // =======================================================
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            FREQ_KHZ <= FREQ_DEFAULT_KHZ; // [RULE6]
            FREQ_VALID <= 1'b0;
            EXT_REF_MODE <= 1'b0;
        end
        else if (CLK_EN)
        begin
            FREQ_KHZ <= freq_nxt;
            FREQ_VALID <= freq_ok;
            // square or sine on the input: the mode is the same
            EXT_REF_MODE <= CRYSTAL_DRIVE_GROUNDED; // [RULE7]
        end
    end

    // =======================================================
    // start-up sequencer, next state
    // =======================================================
    always_comb
    begin
        state_nxt = state_r;
        ms_cnt_nxt = ms_cnt_r;
        delay_nxt = delay_r;
        wait_done = tick_bus.tick && ((ms_cnt_r + 6'h01) == delay_r);
        unique case (state_r)
            ST_IDLE:
            begin
                ms_cnt_nxt = '0;
                if (WAKE_REQ)
                begin
                    state_nxt = ST_WAIT;
                    // zero keeps the base delay, else it is lengthened
                    delay_nxt = BASE_DELAY_MS +
                        {1'b0, CLOCK_STARTUP_EXTENSION}; // [RULE8] [RULE9]
                end
            end
            ST_WAIT:
            begin
                if (!WAKE_REQ)
                    state_nxt = ST_IDLE; // request withdrawn
                else if (wait_done)
                begin
                    state_nxt = ST_RUN; // [RULE12]
                    ms_cnt_nxt = '0;
                end
                else if (tick_bus.tick)
                    ms_cnt_nxt = ms_cnt_r + 6'h01;
            end
            ST_RUN:
            begin
                if (!WAKE_REQ)
                    state_nxt = ST_IDLE;
                // saturate once the radio milestone is reached
                else if (tick_bus.tick && ms_cnt_r < RADIO_MS)
                    ms_cnt_nxt = ms_cnt_r + 6'h01;
            end
            default:
            begin
                state_nxt = ST_IDLE; // unused code recovers to idle
                ms_cnt_nxt = '0;
            end
        endcase
    end

    // =======================================================
    // start-up sequencer, registers
    // =======================================================
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state_r <= ST_IDLE;
            ms_cnt_r <= '0;
            delay_r <= BASE_DELAY_MS;
        end
        else if (CLK_EN)
        begin
            state_r <= state_nxt;
            ms_cnt_r <= ms_cnt_nxt;
            delay_r <= delay_nxt;
        end
    end

    // =======================================================
    // status outputs, decoded from registered state and the power-mode inputs
    // =======================================================
    assign SYS_CLK_REQ = (state_r != ST_IDLE);
    assign FW_RUN = (state_r == ST_RUN); // [RULE12]
    // the far side must be within 250 ppm from here on
    assign ACC250_DUE = FW_RUN && (ms_cnt_r >= ACC250_MS); // [RULE10]
    assign RADIO_ALLOWED = FW_RUN && (ms_cnt_r >= RADIO_MS); // [RULE11]
    // watchdog when asleep, or idle link in low power while firmware runs
    assign PLL_SRC_WDOG = (state_r == ST_IDLE) ||
        (FW_RUN && LOW_POWER && !LINK_ACTIVE); // [RULE2] [RULE3]

    // =======================================================
    // checks
    // =======================================================
    sequence wait_done_s;
        CLK_EN && WAKE_REQ && state_r == ST_WAIT && wait_done;
    endsequence

    sequence wake_s;
        CLK_EN && WAKE_REQ && state_r == ST_IDLE;
    endsequence

    property run_after_wait_p;
        @(posedge SYS_CLK) disable iff (!RST_B)
        wait_done_s |=> FW_RUN;
    endproperty

    property delay_capture_p;
        @(posedge SYS_CLK) disable iff (!RST_B)
        wake_s |=> SYS_CLK_REQ && !FW_RUN && delay_r ==
            BASE_DELAY_MS + {1'b0, $past(CLOCK_STARTUP_EXTENSION)};
    endproperty

    fw_start_a: assert property (run_after_wait_p) // [RULE8]
        else $error("firmware not started at end of delay");

    delay_ext_a: assert property (delay_capture_p) // [RULE9]
        else $error("start-up delay not taken from extension");

    fw_hold_a: assert property ( // [RULE12]
        @(posedge SYS_CLK) disable iff (!RST_B)
        $rose(FW_RUN) |-> $past(ms_cnt_r) + 6'h01 == $past(delay_r)
            && $past(tick_bus.tick))
        else $error("firmware released before delay expired");

    freq_range_a: assert property ( // [RULE1]
        @(posedge SYS_CLK) disable iff (!RST_B)
        FREQ_VALID |-> FREQ_KHZ >= FREQ_MIN_KHZ &&
            FREQ_KHZ <= FREQ_MAX_KHZ)
        else $error("valid frequency out of range");

    freq_step_a: assert property ( // [RULE4]
        @(posedge SYS_CLK) disable iff (!RST_B)
        (CLK_EN && in_range && on_step) |=> FREQ_VALID &&
            FREQ_KHZ == $past(REFERENCE_FREQ_SETTING))
        else $error("250 kHz multiple refused");

    phone_freq_a: assert property ( // [RULE5]
        @(posedge SYS_CLK) disable iff (!RST_B)
        (CLK_EN && (|phone_hit)) |=> FREQ_VALID)
        else $error("phone oscillator frequency refused");

    freq_default_a: assert property ( // [RULE6]
        @(posedge SYS_CLK) disable iff (!RST_B)
        (CLK_EN && !freq_ok) |=> !FREQ_VALID &&
            FREQ_KHZ == FREQ_DEFAULT_KHZ)
        else $error("default frequency not applied");

    ext_ref_a: assert property ( // [RULE7]
        @(posedge SYS_CLK) disable iff (!RST_B)
        CLK_EN |=> EXT_REF_MODE == $past(CRYSTAL_DRIVE_GROUNDED))
        else $error("external reference mode not followed");

    wdog_src_a: assert property ( // [RULE3]
        @(posedge SYS_CLK) disable iff (!RST_B)
        (FW_RUN && LOW_POWER) |-> PLL_SRC_WDOG == !LINK_ACTIVE)
        else $error("watchdog choice ignores link activity");

    acc_due_a: assert property ( // [RULE10]
        @(posedge SYS_CLK) disable iff (!RST_B)
        $rose(ACC250_DUE) |-> FW_RUN && ms_cnt_r == ACC250_MS)
        else $error("accuracy milestone at wrong time");

    radio_gate_a: assert property ( // [RULE11]
        @(posedge SYS_CLK) disable iff (!RST_B)
        RADIO_ALLOWED |-> FW_RUN && ms_cnt_r == RADIO_MS)
        else $error("radio allowed before 6 ms");

    pll_src_a: assert property ( // [RULE2]
        @(posedge SYS_CLK) disable iff (!RST_B)
        !SYS_CLK_REQ |-> PLL_SRC_WDOG)
        else $error("pll not on watchdog while asleep");
endmodule : ref_clock_startup_control

// File: sim/ref_source.sv
`timescale 1ns/100ps
// ==========================================================
// external reference source, settling after firmware start
// ==========================================================
module ref_source
#(
    parameter int unsigned MS = 10
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic en,
    input wire logic tcxo,
    input wire logic fw_run,
    input wire logic acc_due,
    input wire logic radio_ok,
    output logic grounded,
    output logic late
);
    int unsigned run_cyc; // enabled cycles of firmware run
    int unsigned ppm; // present frequency error
    // a tcxo source ties the drive output to ground
    assign grounded = tcxo;
    // settles only just in time, no kinder than required
    assign ppm = run_cyc < 2 * MS ? 1000
        : (run_cyc < 6 * MS ? 200 : 15);
    // flags any milestone raised before the source is ready
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            run_cyc <= 0;
            late <= 1'b0;
        end
        else
        begin
            if (!fw_run)
                run_cyc <= 0;
            else if (en)
                run_cyc <= run_cyc + 1;
            if ((acc_due && ppm > 250) || (radio_ok && ppm > 20))
                late <= 1'b1;
        end
    end
endmodule : ref_source

// File: sim/tb_top.sv
`timescale 1ns/100ps
// ==========================================================
// start-up bench: driver queues notes, monitor compares
// ==========================================================
module tb_top
    import startup_pkg::*;
;
    localparam int unsigned M = 10; // short millisecond for sim
    localparam logic [15:0] PH [9] = '{16'h3840, 16'h3C00, 16'h3F48,
        16'h41A0, 16'h4B00, 16'h4BF0, 16'h4CE0, 16'h4D58, 16'h9600};
    // range ends, off-step and default settings
    localparam logic [15:0] EV [8] = '{16'h2EE0, 16'h2DE6, 16'hCB20,
        16'hCC1A, 16'h2EE1, 16'h3841, 16'h6590, 16'hFFFF};
    logic SYS_CLK = 1'b0;
    logic RST_B = 1'b0;
    logic CLK_EN = 1'b1;
    logic WAKE_REQ = 1'b0;
    logic [15:0] setting = 16'h6590;
    logic [4:0] ext = 5'h00;
    logic tcxo = 1'b0;
    logic LOW_POWER = 1'b0;
    logic LINK_ACTIVE = 1'b0;
    logic grounded, SYS_CLK_REQ, FW_RUN, FREQ_VALID, EXT_REF_MODE;
    logic PLL_SRC_WDOG, ACC250_DUE, RADIO_ALLOWED, WDOG_TICK, late;
    logic [15:0] FREQ_KHZ;
    logic [31:0] seed = 32'hDD8CDC3B; // driver stimulus
    logic [31:0] seed2 = 32'hDD8CDC3B; // power-mode stimulus
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] fq [$]; // pending frequency answers
    logic [31:0] dq [$]; // pending start-up milestones
    logic [31:0] cnt = 0; // enabled cycles since clock request
    logic [31:0] gap = 0; // enabled cycles since last tick
    int arm_n = 0; // two ticks needed after a stall or wake
    logic fw_q = 1'b0, acc_q = 1'b0, rad_q = 1'b0;
    event fev;
    logic [31:0] exp_f; // oldest frequency note
    logic wdog_exp; // expected pll source this edge
    initial
        forever #25 SYS_CLK = ~SYS_CLK;
    ref_clock_startup_control #(.MS_CYC(M)) dut_u (.SYS_CLK(SYS_CLK),
        .RST_B(RST_B), .CLK_EN(CLK_EN), .WAKE_REQ(WAKE_REQ),
        .REFERENCE_FREQ_SETTING(setting), .CLOCK_STARTUP_EXTENSION(ext),
        .CRYSTAL_DRIVE_GROUNDED(grounded), .LOW_POWER(LOW_POWER),
        .LINK_ACTIVE(LINK_ACTIVE), .SYS_CLK_REQ(SYS_CLK_REQ),
        .FW_RUN(FW_RUN), .FREQ_KHZ(FREQ_KHZ), .FREQ_VALID(FREQ_VALID),
        .EXT_REF_MODE(EXT_REF_MODE), .PLL_SRC_WDOG(PLL_SRC_WDOG),
        .ACC250_DUE(ACC250_DUE), .RADIO_ALLOWED(RADIO_ALLOWED),
        .WDOG_TICK(WDOG_TICK));
    ref_source #(.MS(M)) ref_u (.clk(SYS_CLK), .rst_b(RST_B),
        .en(CLK_EN), .tcxo(tcxo), .fw_run(FW_RUN), .acc_due(ACC250_DUE),
        .radio_ok(RADIO_ALLOWED), .grounded(grounded), .late(late));
    // ======================================================
    // helpers
    // ======================================================
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // usable: in range and on the step or a phone frequency
    function automatic logic [16:0] freq_exp(input logic [15:0] v);
        logic ok;
        ok = (v % 16'h00FA) == 16'h0000;
        foreach (PH[i])
            ok = ok || v == PH[i];
        ok = ok && v >= 16'h2EE0 && v <= 16'hCB20;
        return ok ? {1'b1, v} : {1'b0, 16'h6590};
    endfunction : freq_exp
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] seen);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    // answer is due one enabled edge after the setting lands
    task automatic set_freq(input logic [15:0] v);
        @(posedge SYS_CLK);
        setting <= v;
        tcxo <= seed[3];
        fq.push_back({14'h0000, seed[3], freq_exp(v)});
        seed = lfsr(seed);
        repeat (2) @(posedge SYS_CLK);
        ->fev;
    endtask : set_freq
    // one wake, optionally stalled or briefly dropped mid-wait
    task automatic wake(input logic [4:0] e, input logic stall,
        input logic abort);
        logic [31:0] d;
        d = (5 + e) * M;
        @(posedge SYS_CLK);
        ext <= e;
        WAKE_REQ <= 1'b1;
        dq.push_back(d);
        dq.push_back(d + 2 * M);
        dq.push_back(d + 6 * M);
        @(posedge SYS_CLK);
        ext <= ~e; // must be ignored once awake
        repeat (15) @(posedge SYS_CLK);
        CLK_EN <= !stall;
        WAKE_REQ <= !abort;
        ext <= e;
        @(posedge SYS_CLK);
        WAKE_REQ <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
        CLK_EN <= 1'b1;
        for (int i = 0; i < 1200 && RADIO_ALLOWED !== 1'b1; i++)
            @(posedge SYS_CLK);
        repeat (3) @(posedge SYS_CLK);
        WAKE_REQ <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        check("milestones_left", 32'h0, 32'(dq.size()));
        check("fw_off", 32'h0, {SYS_CLK_REQ, FW_RUN});
    endtask : wake
    // ======================================================
    // monitor: results taken against the oldest note
    // ======================================================
    // each answer is split into its fields, one rule group apiece
    always @(fev)
    begin
        exp_f = fq.pop_front();
        check("freq_khz", 32'(exp_f[15:0]), 32'(FREQ_KHZ));
        check("freq_ok", 32'(exp_f[16]), 32'(FREQ_VALID));
        check("ext_ref", 32'(exp_f[17]), 32'(EXT_REF_MODE));
    end
    always @(posedge SYS_CLK)
    begin
        if (RST_B === 1'b1)
        begin
            wdog_exp = !SYS_CLK_REQ || (FW_RUN && LOW_POWER && !LINK_ACTIVE);
            check("wdog_src", 32'(wdog_exp), 32'(PLL_SRC_WDOG));
            if (FW_RUN && !fw_q)
                check("fw_start", dq.pop_front(), cnt);
            if (ACC250_DUE && !acc_q)
                check("acc250", dq.pop_front(), cnt);
            if (RADIO_ALLOWED && !rad_q)
                check("radio", dq.pop_front(), cnt);
            if (WDOG_TICK && CLK_EN)
            begin
                if (arm_n == 2)
                    check("tick_gap", M, gap);
                gap = 1;
                arm_n = arm_n == 2 ? 2 : arm_n + 1;
            end
            else if (CLK_EN)
                gap++;
            if (!SYS_CLK_REQ || !CLK_EN)
                arm_n = 0;
            cnt = !SYS_CLK_REQ ? 0 : (CLK_EN ? cnt + 1 : cnt);
            fw_q = FW_RUN;
            acc_q = ACC250_DUE;
            rad_q = RADIO_ALLOWED;
        end
    end
    // ======================================================
    // power-mode stimulus and hang limit
    // ======================================================
    always @(posedge SYS_CLK)
    begin
        cycles++;
        seed2 = lfsr(seed2);
        LOW_POWER <= seed2[0];
        LINK_ACTIVE <= seed2[5];
        if (cycles == 10000)
        begin
            miscompares++;
            close_out();
        end
    end
    // ======================================================
    // main sequence
    // ======================================================
    initial
    begin
        repeat (10) @(posedge SYS_CLK);
        check("rst_freq", 32'h6590, FREQ_KHZ);
        check("rst_out", 32'h0, {SYS_CLK_REQ, FW_RUN, FREQ_VALID});
        repeat (10) @(posedge SYS_CLK);
        RST_B <= 1'b1;
        foreach (PH[i])
            set_freq(PH[i]);
        foreach (EV[i])
            set_freq(EV[i]);
        repeat (12)
        begin
            set_freq(seed[15:0]);
            set_freq(16'h2EE0 + 16'((seed[31:8] % 161) * 250));
        end
        wake(5'h00, 1'b0, 1'b0);
        wake(5'h1F, 1'b0, 1'b0);
        wake(5'h01, 1'b1, 1'b0);
        wake(seed[4:0], 1'b0, 1'b1);
        wake(seed[9:5], 1'b1, 1'b0);
        check("src_late", 32'h0, late);
        close_out();
    end
endmodule : tb_top
